// ==== buck_command_limits_regs.sv ====
// Command and limits register bank of the step-down regulator, with the pin gating it steers.
// Assumes a serial-bus front end on clk_sys that presents one byte access per strobe.
module buck_command_limits_regs (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Byte access port from the serial-bus front end.
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata_ff,
  // Device pins and analog fault indications, all asynchronous.
  input wire logic en_pin,
  input wire logic voltage_select_pin,
  input wire logic thermal_shutdown,
  input wire logic short_circuit_fault,
  // Voltage transition in progress, from the reference stepper on clk_sys.
  input wire logic dynamic_voltage_scaling,
  // Control outputs to the power stage.
  output logic select_state_ff,
  output logic regulate_en_ff,
  output logic sleep_ff,
  output logic low_iq_ff,
  output logic pseudo_pwm_mode_ff,
  output logic power_up_start_ff,
  output logic fault_off_ff,
  output logic [7:0] warn_temp_c_ff,
  output logic [6:0] current_limit_da_ff
);

  // Synchronised pin levels.
  logic en_s;
  logic sel_s;
  logic thermal_s;
  logic short_s;

  // Register bank state.
  logic [7:0] command_ff;
  logic [7:0] limits_ff;
  logic [7:0] nxt_command;
  logic [7:0] nxt_limits;
  logic [7:0] nxt_rdata;
  // A force-reset request waits one cycle so the write itself completes first.
  logic reload_ff;
  logic nxt_reload;

  // Fault supervision state.
  buck_regs_pkg::fault_state_t state_ff;
  buck_regs_pkg::fault_state_t nxt_state;

  // Next values of the outputs.
  logic nxt_select;
  logic nxt_regulate;
  logic nxt_sleep;
  logic nxt_low_iq;
  logic nxt_pwm_mode;
  logic nxt_start;
  logic nxt_fault_off;
  logic [7:0] nxt_warn;
  logic [6:0] nxt_ilim;

  // Every outside level passes two flip-flops before use.
  pin_sync u_sync_en (.clk_sys(clk_sys), .sys_rst(sys_rst), .async_in(en_pin), .sync_out(en_s));
  pin_sync u_sync_sel (.clk_sys(clk_sys), .sys_rst(sys_rst), .async_in(voltage_select_pin), .sync_out(sel_s));
  pin_sync u_sync_thermal (.clk_sys(clk_sys), .sys_rst(sys_rst), .async_in(thermal_shutdown), .sync_out(thermal_s));
  pin_sync u_sync_short (.clk_sys(clk_sys), .sys_rst(sys_rst), .async_in(short_circuit_fault), .sync_out(short_s));

  // Register writes, force-reset reload and read data.
  always_comb begin
    nxt_command = command_ff;
    nxt_limits = limits_ff;
    nxt_reload = 1'b0;
    nxt_rdata = reg_rdata_ff;
    if (reload_ff) begin
      // Defaults come back and the status flag is set again.
      nxt_command = buck_regs_pkg::MODE_COMMAND_RST;
      nxt_limits = buck_regs_pkg::LIMITS_CONFIG_RST;
    end else if (reg_wr && reg_addr == buck_regs_pkg::MODE_COMMAND_ADDR) begin
      nxt_command = reg_wdata & buck_regs_pkg::MODE_COMMAND_MASK;
    end else if (reg_wr && reg_addr == buck_regs_pkg::LIMITS_CONFIG_ADDR) begin
      // The force bit is never stored, so it always reads back as zero.
      nxt_limits = reg_wdata & buck_regs_pkg::LIMITS_CONFIG_MASK;
      nxt_reload = reg_wdata[buck_regs_pkg::SOFT_REGISTER_RESET_BIT];
    end
    // Reads return the stored value one cycle after the strobe; unmapped addresses read zero.
    if (reg_rd) begin
      if (reg_addr == buck_regs_pkg::MODE_COMMAND_ADDR) begin
        nxt_rdata = command_ff;
      end else if (reg_addr == buck_regs_pkg::LIMITS_CONFIG_ADDR) begin
        nxt_rdata = limits_ff;
      end else begin
        nxt_rdata = 8'h00;
      end
    end
  end

  // Register the bank; a hard reset loads the defaults and so sets the flag.
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      command_ff <= buck_regs_pkg::MODE_COMMAND_RST;
      limits_ff <= buck_regs_pkg::LIMITS_CONFIG_RST;
      reload_ff <= 1'b0;
      reg_rdata_ff <= 8'h00;
    end else begin
      command_ff <= nxt_command;
      limits_ff <= nxt_limits;
      reload_ff <= nxt_reload;
      reg_rdata_ff <= nxt_rdata;
    end
  end

  // Fault supervision: a fault turns the stage off until re-armed or hard reset.
  always_comb begin
    nxt_state = state_ff;
    nxt_start = 1'b0;
    case (state_ff)
      buck_regs_pkg::ST_RUN: begin
        if (thermal_s || short_s) begin
          nxt_state = buck_regs_pkg::ST_FAULT;
        end
      end
      buck_regs_pkg::ST_FAULT: begin
        // Register values are left alone; only the power-up sequence restarts.
        if (!thermal_s && !short_s && limits_ff[buck_regs_pkg::FAULT_RESTART_EN_BIT]) begin
          nxt_state = buck_regs_pkg::ST_RESTART;
          nxt_start = 1'b1;
        end
      end
      buck_regs_pkg::ST_RESTART: begin
        nxt_state = buck_regs_pkg::ST_RUN;
      end
      default: begin
        nxt_state = buck_regs_pkg::ST_FAULT;
      end
    endcase
  end

  // Output decode from the command bits and pins.
  always_comb begin
    // With the select pin disabled the state-one voltage is used.
    nxt_select = command_ff[buck_regs_pkg::SELECT_PIN_GATE_EN_BIT] ? sel_s : 1'b1;
    // The enable pin only gates regulation if gating is on for the present state.
    if (nxt_select) begin
      nxt_regulate = command_ff[buck_regs_pkg::EN_GATE_SEL_HIGH_BIT] ? en_s : 1'b1;
    end else begin
      nxt_regulate = command_ff[buck_regs_pkg::EN_GATE_SEL_LOW_BIT] ? en_s : 1'b1;
    end
    // Sleep forced by the bit; otherwise low current when both pins are low.
    nxt_sleep = command_ff[buck_regs_pkg::SLEEP_MODE_BIT];
    nxt_low_iq = !command_ff[buck_regs_pkg::SLEEP_MODE_BIT] && !en_s && !sel_s;
    nxt_regulate = nxt_regulate && !nxt_sleep && (nxt_state == buck_regs_pkg::ST_RUN);
    // Transition mode overrides the per-state mode while the voltage is moving.
    if (dynamic_voltage_scaling) begin
      nxt_pwm_mode = command_ff[buck_regs_pkg::TRANSITION_MODE_SEL_BIT];
    end else if (nxt_select) begin
      nxt_pwm_mode = command_ff[buck_regs_pkg::FORCED_PSEUDO_PWM_HIGH_BIT];
    end else begin
      nxt_pwm_mode = command_ff[buck_regs_pkg::FORCED_PSEUDO_PWM_LOW_BIT];
    end
    nxt_fault_off = (nxt_state == buck_regs_pkg::ST_FAULT);
    // Thermal threshold lookup.
    case (limits_ff[buck_regs_pkg::THERMAL_WARN_LSB +: 2])
      2'h0: nxt_warn = buck_regs_pkg::WARN_TEMP_CODE0;
      2'h1: nxt_warn = buck_regs_pkg::WARN_TEMP_CODE1;
      2'h2: nxt_warn = buck_regs_pkg::WARN_TEMP_CODE2;
      default: nxt_warn = buck_regs_pkg::WARN_TEMP_CODE3;
    endcase
    // Peak-current lookup.
    case (limits_ff[buck_regs_pkg::INDUCTOR_LIMIT_LSB +: 2])
      2'h0: nxt_ilim = buck_regs_pkg::ILIM_CODE0;
      2'h1: nxt_ilim = buck_regs_pkg::ILIM_CODE1;
      2'h2: nxt_ilim = buck_regs_pkg::ILIM_CODE2;
      default: nxt_ilim = buck_regs_pkg::ILIM_CODE3;
    endcase
  end

  // Register the state and every control output; the stage stays off during reset.
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      state_ff <= buck_regs_pkg::ST_RUN;
      select_state_ff <= 1'b1;
      regulate_en_ff <= 1'b0;
      sleep_ff <= 1'b0;
      low_iq_ff <= 1'b0;
      pseudo_pwm_mode_ff <= 1'b0;
      power_up_start_ff <= 1'b0;
      fault_off_ff <= 1'b0;
      warn_temp_c_ff <= buck_regs_pkg::WARN_TEMP_CODE0;
      current_limit_da_ff <= buck_regs_pkg::ILIM_CODE0;
    end else begin
      state_ff <= nxt_state;
      select_state_ff <= nxt_select;
      regulate_en_ff <= nxt_regulate;
      sleep_ff <= nxt_sleep;
      low_iq_ff <= nxt_low_iq;
      pseudo_pwm_mode_ff <= nxt_pwm_mode;
      power_up_start_ff <= nxt_start;
      fault_off_ff <= nxt_fault_off;
      warn_temp_c_ff <= nxt_warn;
      current_limit_da_ff <= nxt_ilim;
    end
  end

  // A force-reset write brings both registers back to defaults two edges later.
  a_force_reset_reload: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (!reload_ff && reg_wr && reg_addr == buck_regs_pkg::LIMITS_CONFIG_ADDR && reg_wdata[2])
    |-> ##2 (command_ff == buck_regs_pkg::MODE_COMMAND_RST && limits_ff == buck_regs_pkg::LIMITS_CONFIG_RST))
    else $error("Force reset did not reload defaults.");

  // The force bit never reads back as one.
  a_force_bit_clear: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !limits_ff[buck_regs_pkg::SOFT_REGISTER_RESET_BIT])
    else $error("Force reset bit was stored.");

  // After a reload the status flag reads one.
  a_flag_after_reload: assert property (@(posedge clk_sys) disable iff (sys_rst)
    reload_ff |=> limits_ff[buck_regs_pkg::DEFAULTS_LOADED_FLAG_BIT])
    else $error("Status flag not set by default reload.");

  // With the select pin disabled the state is high one edge later.
  a_select_forced_high: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !command_ff[0] |=> select_state_ff)
    else $error("Select state not forced high.");

  // Gating on in the high state with the enable pin low keeps the stage off.
  a_en_gate_high: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (command_ff[2] && nxt_select && !en_s) |=> !regulate_en_ff)
    else $error("Enable gating in high state ignored.");

  // Gating off in the low state lets a running, awake stage regulate.
  a_en_gate_low: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (!command_ff[3] && !nxt_select && !command_ff[4] && nxt_state == buck_regs_pkg::ST_RUN) |=> regulate_en_ff)
    else $error("Low state regulation blocked without gating.");

  // Forced sleep shows on the sleep output one edge later.
  a_sleep_forced: assert property (@(posedge clk_sys) disable iff (sys_rst)
    command_ff[4] |=> (sleep_ff && !low_iq_ff && !regulate_en_ff))
    else $error("Forced sleep not applied.");

  // During a transition the transition bit decides the mode.
  a_transition_mode: assert property (@(posedge clk_sys) disable iff (sys_rst)
    dynamic_voltage_scaling |=> (pseudo_pwm_mode_ff == $past(command_ff[5])))
    else $error("Transition mode bit not applied.");

  // Outside a transition the low select state takes its own mode bit.
  a_state_mode: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (!dynamic_voltage_scaling && !nxt_select) |=> (pseudo_pwm_mode_ff == $past(command_ff[7])))
    else $error("Low state mode bit not applied.");

  // Re-armed faults restart at the next edge once the fault clears.
  a_fault_restart_en_restart: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (state_ff == buck_regs_pkg::ST_FAULT && !thermal_s && !short_s && limits_ff[0]) |=> power_up_start_ff ##1 !fault_off_ff)
    else $error("Re-arm did not restart power-up.");

  // Without re-arm the device stays off.
  a_no_fault_restart_en: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (state_ff == buck_regs_pkg::ST_FAULT && !limits_ff[0]) |=> (state_ff == buck_regs_pkg::ST_FAULT && !power_up_start_ff))
    else $error("Restarted without re-arm.");

  // Thermal code three reads 116 degrees.
  a_warn_lookup: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (limits_ff[5:4] == 2'h3) |=> (warn_temp_c_ff == 8'h74))
    else $error("Thermal threshold lookup wrong.");

  // Current code zero reads 5.2 A.
  a_ilim_lookup: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (limits_ff[7:6] == 2'h0) |=> (current_limit_da_ff == 7'h34))
    else $error("Current limit lookup wrong.");

  // With the select pin enabled the state follows the synchronised pin.
  a_select_follows_pin: assert property (@(posedge clk_sys) disable iff (sys_rst)
    command_ff[0] |=> (select_state_ff == $past(sel_s)))
    else $error("Select state does not follow the pin.");

  // Sleep bit clear with both pins low enters the low-current mode.
  a_low_iq_entry: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (!command_ff[4] && !en_s && !sel_s) |=> low_iq_ff)
    else $error("Low current mode not entered.");

  // Outside a transition the high select state takes its own mode bit.
  a_state_mode_high: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (!dynamic_voltage_scaling && nxt_select) |=> (pseudo_pwm_mode_ff == $past(command_ff[6])))
    else $error("High state mode bit not applied.");

  // A fault seen while running turns the stage off at the next edge.
  a_fault_turns_off: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (state_ff == buck_regs_pkg::ST_RUN && (thermal_s || short_s)) |=> (fault_off_ff && !regulate_en_ff))
    else $error("Fault did not turn the stage off.");

  // A restart pulse only ever follows the fault state.
  a_start_after_fault: assert property (@(posedge clk_sys) disable iff (sys_rst)
    power_up_start_ff |-> ($past(state_ff) == buck_regs_pkg::ST_FAULT))
    else $error("Restart pulse without a fault.");

  // Thermal code zero reads 83 degrees.
  a_warn_low: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (limits_ff[5:4] == 2'h0) |=> (warn_temp_c_ff == 8'h53))
    else $error("Lowest thermal threshold wrong.");

  // Current code three reads 6.8 A.
  a_ilim_top: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (limits_ff[7:6] == 2'h3) |=> (current_limit_da_ff == 7'h44))
    else $error("Highest current limit wrong.");

endmodule

// ==== buck_regs_pkg.sv ====
// Constants shared by the regulator's command and limits register bank.
// Assumes a serial-bus front end that turns host transfers into byte-wide register accesses.
package buck_regs_pkg;

  // Register byte addresses.
  localparam logic [7:0] MODE_COMMAND_ADDR = 8'h14;
  localparam logic [7:0] LIMITS_CONFIG_ADDR = 8'h16;

  // Reset values; the flag bit of the limits register is set by default.
  localparam logic [7:0] MODE_COMMAND_RST = 8'h00;
  localparam logic [7:0] LIMITS_CONFIG_RST = 8'h02;

  // Field positions of the mode command register.
  localparam int SELECT_PIN_GATE_EN_BIT = 0;
  localparam int EN_GATE_SEL_HIGH_BIT = 2;
  localparam int EN_GATE_SEL_LOW_BIT = 3;
  localparam int SLEEP_MODE_BIT = 4;
  localparam int TRANSITION_MODE_SEL_BIT = 5;
  localparam int FORCED_PSEUDO_PWM_HIGH_BIT = 6;
  localparam int FORCED_PSEUDO_PWM_LOW_BIT = 7;

  // Mask of the implemented bits; the spare bit reads zero.
  localparam logic [7:0] MODE_COMMAND_MASK = 8'hFD;

  // Field positions of the limits configuration register.
  localparam int FAULT_RESTART_EN_BIT = 0;
  localparam int DEFAULTS_LOADED_FLAG_BIT = 1;
  localparam int SOFT_REGISTER_RESET_BIT = 2;
  localparam int THERMAL_WARN_LSB = 4;
  localparam int INDUCTOR_LIMIT_LSB = 6;

  // Stored bits of the limits register; spare and self-clearing bits read zero.
  localparam logic [7:0] LIMITS_CONFIG_MASK = 8'hF3;

  // Thermal pre-warning thresholds in degrees Celsius, indexed by the field code.
  localparam logic [7:0] WARN_TEMP_CODE0 = 8'h53;
  localparam logic [7:0] WARN_TEMP_CODE1 = 8'h5E;
  localparam logic [7:0] WARN_TEMP_CODE2 = 8'h69;
  localparam logic [7:0] WARN_TEMP_CODE3 = 8'h74;

  // Inductor peak-current limits in tenths of an ampere, indexed by the field code.
  localparam logic [6:0] ILIM_CODE0 = 7'h34;
  localparam logic [6:0] ILIM_CODE1 = 7'h3A;
  localparam logic [6:0] ILIM_CODE2 = 7'h3E;
  localparam logic [6:0] ILIM_CODE3 = 7'h44;

  // Fault supervision states.
  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_FAULT = 2'b01,
    ST_RESTART = 2'b10
  } fault_state_t;

endpackage

// ==== pin_sync.sv ====
// Two-stage synchroniser for a single level arriving from outside the clock domain.
// Assumes the level is slow against clk_sys; pulses shorter than one cycle may be lost.
module pin_sync (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Asynchronous level in, synchronised level out.
  input wire logic async_in,
  output logic sync_out
);

  // The first stage may go metastable, so only the second stage reads it.
  logic meta_ff;
  logic nxt_meta;
  logic nxt_sync;

  // Both stages simply follow the stage before them.
  always_comb begin
    nxt_meta = async_in;
    nxt_sync = meta_ff;
  end

  // Register the two stages; reset puts both low.
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      meta_ff <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      meta_ff <= nxt_meta;
      sync_out <= nxt_sync;
    end
  end

endmodule

// ==== host_model.sv ====
// Host model for the command and limits bank: one byte access per call.
// Assumes clk_sys comes from the bench; strobes are driven 1 ns after a rising edge.
module host_model (
  // Clock.
  input wire logic clk_sys,
  // Register byte port towards the bank.
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [7:0] reg_rdata_ff
);
  timeunit 1ns;
  timeprecision 100ps;

  // Idle bus at time zero, no strobe raised before reset release.
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end

  // One write; released lines show inverted values so stale data never looks valid.
  task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
    @(posedge clk_sys);
    #1;
    reg_addr = addr;
    reg_wdata = data;
    reg_wr = 1'b1;
    @(posedge clk_sys);
    #1;
    reg_wr = 1'b0;
    reg_addr = ~addr;
    reg_wdata = ~data;
  endtask

  // One read; the data is registered at the strobe edge, so it is taken just after it.
  task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
    @(posedge clk_sys);
    #1;
    reg_addr = addr;
    reg_rd = 1'b1;
    @(posedge clk_sys);
    #1;
    data = reg_rdata_ff;
    reg_rd = 1'b0;
    reg_addr = ~addr;
  endtask
endmodule

// ==== buck_command_limits_regs_test.sv ====
// Self-checking bench for the command and limits register bank.
// Assumes the host model drives the byte port; pins are driven here 1 ns after an edge.
module buck_command_limits_regs_test;
  timeunit 1ns;
  timeprecision 100ps;

  // Clock, reset and pins.
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic en_pin = 1'b0;
  logic voltage_select_pin = 1'b0;
  logic thermal_shutdown = 1'b0;
  logic short_circuit_fault = 1'b0;
  logic dynamic_voltage_scaling = 1'b0;
  // Byte port and outputs.
  logic [7:0] reg_addr, reg_wdata, reg_rdata_ff, warn_temp_c_ff, v;
  logic reg_wr, reg_rd, select_state_ff, regulate_en_ff, sleep_ff, low_iq_ff;
  logic pseudo_pwm_mode_ff, power_up_start_ff, fault_off_ff;
  logic [6:0] current_limit_da_ff;
  // Reference model state and counters.
  int cmd = 0;
  int lim = 2;
  int warn_tab[4] = '{83, 94, 105, 116};
  int ilim_tab[4] = '{52, 58, 62, 68};
  int miscompares = 0;
  int check_count = 0;
  int n;

  always #5 clk_sys = ~clk_sys;

  host_model u_host_model (.clk_sys, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_ff);

  buck_command_limits_regs u_buck_command_limits_regs (.clk_sys, .sys_rst, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata_ff, .en_pin, .voltage_select_pin, .thermal_shutdown,
    .short_circuit_fault, .dynamic_voltage_scaling, .select_state_ff, .regulate_en_ff, .sleep_ff,
    .low_iq_ff, .pseudo_pwm_mode_ff, .power_up_start_ff, .fault_off_ff, .warn_temp_c_ff,
    .current_limit_da_ff);

  // Verdict and end of run.
  task automatic complete_run();
    if (miscompares == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Single comparison point.
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Read back one register and compare with the model.
  task automatic rd_chk(input logic [7:0] addr, input int exp);
    logic [7:0] d;
    u_host_model.read_reg(addr, d);
    check("readback", d, 8'(exp));
  endtask

  // Expected pin-steered outputs, worked out from the command model and the pins.
  task automatic chk_out();
    logic sel, en_ok;
    sel = cmd[0] ? voltage_select_pin : 1'b1;
    en_ok = (sel ? cmd[2] : cmd[3]) ? en_pin : 1'b1;
    check("select", {7'h00, select_state_ff}, {7'h00, sel});
    check("sleep", {7'h00, sleep_ff}, {7'h00, cmd[4]});
    check("low_iq", {7'h00, low_iq_ff}, {7'h00, !cmd[4] && !en_pin && !voltage_select_pin});
    check("regulate", {7'h00, regulate_en_ff}, {7'h00, en_ok && !cmd[4]});
    check("pwm_mode", {7'h00, pseudo_pwm_mode_ff},
      {7'h00, dynamic_voltage_scaling ? cmd[5] : (sel ? cmd[6] : cmd[7])});
  endtask

  // Bounded wait for the restart pulse; running out ends the run.
  task automatic wait_start();
    n = 0;
    while (power_up_start_ff !== 1'b1) begin
      @(posedge clk_sys);
      #1;
      n++;
      if (n > 30) begin
        miscompares++;
        complete_run();
      end
    end
  endtask

  // Main sequence.
  initial begin
    void'($urandom(71));
    repeat (4) @(posedge clk_sys);
    #1;
    sys_rst = 1'b0;
    rd_chk(8'h14, 0);
    rd_chk(8'h16, 2);
    rd_chk(8'h15, 0);
    chk_out();
    // Random command bytes against random pin levels.
    for (int i = 0; i < 32; i++) begin
      v = 8'($urandom);
      u_host_model.write_reg(8'h14, v);
      cmd = v & 8'hFD;
      {en_pin, voltage_select_pin, dynamic_voltage_scaling} = 3'($urandom);
      repeat (5) @(posedge clk_sys);
      #1;
      chk_out();
      rd_chk(8'h14, cmd);
    end
    // Every threshold and limit code; the flag is written to 0 by the host each time.
    for (int i = 0; i < 16; i++) begin
      lim = (i << 4) | (i & 1);
      u_host_model.write_reg(8'h16, 8'(lim));
      repeat (2) @(posedge clk_sys);
      #1;
      check("warn", warn_temp_c_ff, 8'(warn_tab[i % 4]));
      check("ilim", {1'b0, current_limit_da_ff}, 8'(ilim_tab[i / 4]));
      rd_chk(8'h16, lim);
    end
    // An unmapped write must not land anywhere.
    u_host_model.write_reg(8'h15, 8'hFF);
    rd_chk(8'h14, cmd);
    rd_chk(8'h16, lim);
    // Thermal fault with restart enabled: off, pulse, back on, registers kept.
    thermal_shutdown = 1'b1;
    repeat (5) @(posedge clk_sys);
    #1;
    check("fault_off", {7'h00, fault_off_ff}, 8'h01);
    check("regulate", {7'h00, regulate_en_ff}, 8'h00);
    thermal_shutdown = 1'b0;
    wait_start();
    check("fault_off", {7'h00, fault_off_ff}, 8'h00);
    repeat (2) @(posedge clk_sys);
    #1;
    chk_out();
    rd_chk(8'h16, lim);
    rd_chk(8'h14, cmd);
    // Short circuit with restart disabled: the stage stays off.
    lim = 8'hF0;
    u_host_model.write_reg(8'h16, 8'(lim));
    short_circuit_fault = 1'b1;
    repeat (5) @(posedge clk_sys);
    #1;
    short_circuit_fault = 1'b0;
    repeat (20) @(posedge clk_sys);
    #1;
    check("fault_off", {7'h00, fault_off_ff}, 8'h01);
    rd_chk(8'h16, lim);
    // Forced reload: defaults return, flag set, force bit reads back 0.
    u_host_model.write_reg(8'h16, 8'hF4);
    repeat (2) @(posedge clk_sys);
    rd_chk(8'h16, 2);
    rd_chk(8'h14, 0);
    check("warn", warn_temp_c_ff, 8'h53);
    check("ilim", {1'b0, current_limit_da_ff}, 8'h34);
    // Host clears the flag; a hard reset in mid-run sets it again and clears the fault latch.
    u_host_model.write_reg(8'h16, 8'h00);
    rd_chk(8'h16, 0);
    sys_rst = 1'b1;
    repeat (4) @(posedge clk_sys);
    #1;
    sys_rst = 1'b0;
    rd_chk(8'h16, 2);
    check("fault_off", {7'h00, fault_off_ff}, 8'h00);
    complete_run();
  end
endmodule
